// *** rtl/dac_serial_ctl.sv ***
// Purpose: serial word capture, readback shifting, holding/active buffers, update and clear
// Assumes: serial clock stands still outside frames; 24-bit words only
// Notes:   link logic runs on the serial clock, buffers on the system clock
`timescale 1ns/1ps
`default_nettype none

// word fifo between the frame catcher and the executor
module word_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];  // storage
  logic [PW:0]      wr_ptr_r;       // extra bit tells full from empty
  logic [PW:0]      rd_ptr_r;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  assign in_ready_o  = (wr_ptr_r[PW] == rd_ptr_r[PW]) || (wr_ptr_r[PW-1:0] != rd_ptr_r[PW-1:0]);
  assign out_valid_o = (wr_ptr_r != rd_ptr_r);
  assign out_data_o  = mem_r[rd_ptr_r[PW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage write, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[PW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

// Operation
// (R01) capture input on rising edges while selected
// (R02) readback bit changes on falling edges
// (R03) readback starts after address lsb captured
// (R04) update input low copies all channels
// (R05) clear input low zeroes active code, span
// (R06) flag low after reset or clear
// (R07) flag high once update executed
// (R08) 24-bit word: command, address, data, msb first
// (R09) readback high impedance while deselected
// (R10) update copies holding into active buffers
// (R11) host keeps select high during update
// (R12) clear wins over simultaneous update
module dac_serial_ctl
  import dac_ctl_pkg::*;
(
  input  wire logic                  MCLK_I,
  input  wire logic                  RESET_N_I,
  input  wire logic                  SCK_I,
  input  wire logic                  SELECT_LOAD_N_I,
  input  wire logic                  SERIAL_IN_I,
  input  wire logic                  ASYNC_UPDATE_N_I,
  input  wire logic                  ASYNC_CLEAR_N_I,
  output logic                       READBACK_OUT_O,
  output logic                       READBACK_OE_O,
  output logic                       RESET_FLAG_N_O,
  output chan_t [CHANNELS-1:0]       ACTIVE_O,
  output logic  [CHANNELS-1:0]       SLEEP_O
);

  // ---------------- link domain (serial clock) ----------------
  logic [CNT_BITS-1:0]  bit_cnt_r;     // rising edges seen in this frame
  logic [WORD_BITS-1:0] shift_r;       // incoming bits
  word_t                word_r;        // last complete word, steady until next
  logic                 word_tgl_r;    // flips once per complete word
  logic [DATA_BITS-1:0] rb_shift_r;    // outgoing readback bits
  logic [WORD_BITS-1:0] shift_nxt;     // shift register with the new bit

  assign shift_nxt = {shift_r[WORD_BITS-2:0], SERIAL_IN_I};

  // frame edge counter; select high ends the frame without a clock edge
  always_ff @(posedge SCK_I or posedge SELECT_LOAD_N_I) begin
    if (SELECT_LOAD_N_I) begin
      bit_cnt_r <= '0;
    end else if (bit_cnt_r != LAST_EDGE + 1'b1) begin
      // saturate so a long frame cannot wrap into a second word
      bit_cnt_r <= bit_cnt_r + 1'b1;
    end
  end

  // (R01) rising-edge capture
  always_ff @(posedge SCK_I or posedge SELECT_LOAD_N_I) begin
    if (SELECT_LOAD_N_I) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // (R08) 24th edge completes the word
  always_ff @(posedge SCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      word_r     <= '0;
      word_tgl_r <= 1'b0;
    end else if (!SELECT_LOAD_N_I && bit_cnt_r == LAST_EDGE) begin
      word_r     <= word_t'(shift_nxt);
      word_tgl_r <= ~word_tgl_r;
    end
  end

  // readback path on falling edges; select high floats the pin at once
  logic [DATA_BITS-1:0] rb_word_r;     // system-domain value, steady during frames
  // (R02) falling-edge shift out
  always_ff @(negedge SCK_I or posedge SELECT_LOAD_N_I) begin
    if (SELECT_LOAD_N_I) begin
      // (R09) deselected, pin floats
      READBACK_OE_O  <= 1'b0;
      READBACK_OUT_O <= 1'b0;
      rb_shift_r     <= '0;
    end else begin
      READBACK_OE_O <= 1'b1;
      // (R03) start after address lsb
      if (bit_cnt_r == RB_START) begin
        READBACK_OUT_O <= rb_word_r[DATA_BITS-1];
        rb_shift_r     <= {rb_word_r[DATA_BITS-2:0], 1'b0};
      end else if (bit_cnt_r > RB_START) begin
        READBACK_OUT_O <= rb_shift_r[DATA_BITS-1];
        rb_shift_r     <= {rb_shift_r[DATA_BITS-2:0], 1'b0};
      end else begin
        // low until readback data begins
        READBACK_OUT_O <= 1'b0;
      end
    end
  end

  // ---------------- system domain ----------------
  logic [SYNC_BITS-1:0] sync1_r;       // first stage, read only by sync2_r
  logic [SYNC_BITS-1:0] sync2_r;       // usable levels
  logic                 tgl_seen_r;    // last toggle level handled
  logic                 pend_v_r;      // word waiting for the fifo
  word_t                pend_r;
  logic                 fifo_in_rdy;
  logic                 fifo_out_v;
  logic [WORD_BITS-1:0] fifo_out_d;
  logic                 exec_rdy;
  logic                 upd_n_s;       // synchronised update level
  logic                 clr_n_s;       // synchronised clear level

  assign upd_n_s = sync2_r[SY_UPD];
  assign clr_n_s = sync2_r[SY_CLR];

  // two-flop synchronisers; idle levels are high for update and clear
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      sync1_r <= 3'h6;
      sync2_r <= 3'h6;
    end else begin
      sync1_r <= {ASYNC_CLEAR_N_I, ASYNC_UPDATE_N_I, word_tgl_r};
      sync2_r <= sync1_r;
    end
  end

  // toggle seen: word_r has been steady for two system edges already
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      tgl_seen_r <= 1'b0;
      pend_v_r   <= 1'b0;
      pend_r     <= '0;
    end else begin
      if (sync2_r[SY_TGL] != tgl_seen_r) begin
        tgl_seen_r <= sync2_r[SY_TGL];
        pend_v_r   <= 1'b1;
        pend_r     <= word_r;
      end else if (fifo_in_rdy) begin
        pend_v_r <= 1'b0;
      end
    end
  end

  // executor stalls while clear holds, so the fifo can fill
  assign exec_rdy = clr_n_s;

  word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (MCLK_I),
    .rst_n_i     (RESET_N_I),
    .in_valid_i  (pend_v_r),
    .in_ready_o  (fifo_in_rdy),
    .in_data_i   (pend_r),
    .out_valid_o (fifo_out_v),
    .out_ready_i (exec_rdy),
    .out_data_o  (fifo_out_d)
  );

  // command decode
  word_t              cmd_w;
  logic               fire;
  logic               wr_span;
  logic               wr_code;
  logic               upd_one;
  logic               upd_all;
  logic               do_sleep;
  logic [CH_BITS-1:0] cmd_ch;

  assign cmd_w  = word_t'(fifo_out_d);
  assign fire   = fifo_out_v && exec_rdy;
  assign cmd_ch = cmd_w.addr[CH_BITS-1:0];

  always_comb begin
    wr_span  = 1'b0;
    wr_code  = 1'b0;
    upd_one  = 1'b0;
    upd_all  = 1'b0;
    do_sleep = 1'b0;
    unique case (cmd_w.cmd)
      CMD_WR_SPAN:      wr_span = 1'b1;
      CMD_WR_CODE:      wr_code = 1'b1;
      CMD_UPD_CH:       upd_one = 1'b1;
      CMD_UPD_ALL:      upd_all = 1'b1;
      CMD_WR_SPAN_UPD:  begin
        wr_span = 1'b1;
        upd_one = 1'b1;
      end
      CMD_WR_CODE_UPD:  begin
        wr_code = 1'b1;
        upd_one = 1'b1;
      end
      CMD_WR_SPAN_UALL: begin
        wr_span = 1'b1;
        upd_all = 1'b1;
      end
      CMD_WR_CODE_UALL: begin
        wr_code = 1'b1;
        upd_all = 1'b1;
      end
      CMD_SLEEP:        do_sleep = 1'b1;
      // reads, no-op and reserved codes change no buffer
      default:          wr_span = 1'b0;
    endcase
  end

  // per-channel holding and active buffers
  chan_t [CHANNELS-1:0] hold_r;        // holding buffers
  chan_t [CHANNELS-1:0] hold_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      logic hit;                       // command addresses this channel
      assign hit = fire && (cmd_ch == CH_BITS'(gi));

      always_comb begin
        hold_nxt[gi] = hold_r[gi];
        if (hit && wr_span) begin
          hold_nxt[gi].span = cmd_w.data[SPAN_BITS-1:0];
        end
        if (hit && wr_code) begin
          hold_nxt[gi].code = cmd_w.data;
        end
      end

      // holding buffer, never touched by clear
      always_ff @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
          hold_r[gi] <= '0;
        end else begin
          hold_r[gi] <= hold_nxt[gi];
        end
      end

      // active buffer; clear first, then pin update, then commands
      always_ff @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
          ACTIVE_O[gi] <= '0;
        // (R05) clear zeroes buffers
        end else if (!clr_n_s) begin
          // (R12) clear beats update
          ACTIVE_O[gi].code <= ZERO_DATA;
          ACTIVE_O[gi].span <= ZERO_SPAN;
        // (R04) pin update copies
        end else if (!upd_n_s) begin
          ACTIVE_O[gi] <= hold_r[gi];
        // (R10) command update copies
        end else if ((fire && upd_all) || (hit && upd_one)) begin
          // write-and-update takes the freshly written value
          ACTIVE_O[gi] <= hold_nxt[gi];
        end
      end

      // sleep set by command, woken by any update of the channel
      always_ff @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
          SLEEP_O[gi] <= 1'b0;
        end else if (!upd_n_s || (fire && upd_all) || (hit && upd_one)) begin
          SLEEP_O[gi] <= 1'b0;
        end else if (hit && do_sleep) begin
          SLEEP_O[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // reset flag: low from reset or clear until an update runs
  always_ff @(posedge MCLK_I) begin
    // (R06) low on reset, clear
    if (!RESET_N_I || !clr_n_s) begin
      RESET_FLAG_N_O <= 1'b0;
    // (R07) release on update
    end else if (!upd_n_s || (fire && (upd_one || upd_all))) begin
      RESET_FLAG_N_O <= 1'b1;
    end
  end

  // readback pointer for the next word
  rb_sel_t rb_sel_r;
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      rb_sel_r <= '0;
    end else if (fire) begin
      rb_sel_r.ch <= cmd_ch;
      unique case (cmd_w.cmd)
        CMD_WR_SPAN, CMD_RD_B1_SPAN: begin
          rb_sel_r.active <= 1'b0;
          rb_sel_r.span   <= 1'b1;
        end
        CMD_WR_CODE, CMD_RD_B1_CODE: begin
          rb_sel_r.active <= 1'b0;
          rb_sel_r.span   <= 1'b0;
        end
        CMD_UPD_ALL: begin
          // points at active code of channel zero
          rb_sel_r.active <= 1'b1;
          rb_sel_r.span   <= 1'b0;
          rb_sel_r.ch     <= '0;
        end
        CMD_UPD_CH, CMD_WR_SPAN_UPD, CMD_WR_SPAN_UALL, CMD_RD_B2_SPAN, CMD_SLEEP: begin
          rb_sel_r.active <= 1'b1;
          rb_sel_r.span   <= 1'b1;
        end
        default: begin
          rb_sel_r.active <= 1'b1;
          rb_sel_r.span   <= 1'b0;
        end
      endcase
    end
  end

  // readback word; span words carry the sleep bit just above the span bits
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      rb_word_r <= '0;
    end else begin
      unique case ({rb_sel_r.active, rb_sel_r.span})
        2'h0: rb_word_r <= hold_r[rb_sel_r.ch].code;
        2'h1: rb_word_r <= {11'h000, SLEEP_O[rb_sel_r.ch], hold_r[rb_sel_r.ch].span};
        2'h2: rb_word_r <= ACTIVE_O[rb_sel_r.ch].code;
        2'h3: rb_word_r <= {11'h000, SLEEP_O[rb_sel_r.ch], ACTIVE_O[rb_sel_r.ch].span};
      endcase
    end
  end

  // ---------------- checks ----------------
  clear_zero_a: assert property (  // R05
    @(posedge MCLK_I) disable iff (!RESET_N_I) !clr_n_s |=> (ACTIVE_O == '0))
    else $error("active buffers not zero during clear");

  clear_wins_a: assert property (  // R12
    @(posedge MCLK_I) disable iff (!RESET_N_I)
    (!clr_n_s && !upd_n_s) |=> (ACTIVE_O == '0) && !RESET_FLAG_N_O)
    else $error("update overrode clear");

  flag_low_a: assert property (  // R06
    @(posedge MCLK_I) disable iff (!RESET_N_I) $fell(clr_n_s) |=> !RESET_FLAG_N_O [*2])
    else $error("reset flag not low after clear");

  flag_release_a: assert property (  // R07
    @(posedge MCLK_I) disable iff (!RESET_N_I)
    (clr_n_s && !upd_n_s) ##1 clr_n_s |-> RESET_FLAG_N_O)
    else $error("reset flag not released by update");

  pin_update_a: assert property (  // R04
    @(posedge MCLK_I) disable iff (!RESET_N_I)
    (clr_n_s && !upd_n_s) |=> (ACTIVE_O == $past(hold_r)))
    else $error("update pin did not copy holding buffers");

  cmd_update_a: assert property (  // R10
    @(posedge MCLK_I) disable iff (!RESET_N_I)
    (clr_n_s && upd_n_s && fire && upd_all) |=> (ACTIVE_O == $past(hold_nxt)))
    else $error("update command did not copy holding buffers");

  // checked on the falling edge inside the frame, before select can rise and abort it
  word_capture_a: assert property (  // R01
    @(negedge SCK_I) disable iff (SELECT_LOAD_N_I)
    (bit_cnt_r == LAST_EDGE + 1'b1) |-> (word_r == word_t'(shift_r)))
    else $error("word not captured on last edge");

  rb_quiet_a: assert property (  // R03
    @(negedge SCK_I) disable iff (SELECT_LOAD_N_I)
    (bit_cnt_r < RB_START) |=> !READBACK_OUT_O && READBACK_OE_O)
    else $error("readback began before address lsb");

  float_a: assert property (  // R09
    @(posedge MCLK_I) disable iff (!RESET_N_I)
    (SELECT_LOAD_N_I && $past(SELECT_LOAD_N_I)) |-> !READBACK_OE_O)
    else $error("readback driven while deselected");

endmodule

`default_nettype wire

// *** rtl/dac_ctl_pkg.sv ***
// Purpose: shared constants and types for the quad DAC serial control front end
// Assumes: 24-bit serial words, four channels, 16-bit codes and 4-bit spans
// Notes:   the command encodings are the 4-bit values carried in the word's top nibble
package dac_ctl_pkg;

  localparam int unsigned CHANNELS   = 4;    // number of DAC channels
  localparam int unsigned CMD_BITS   = 4;    // command field width
  localparam int unsigned ADDR_BITS  = 4;    // address field width
  localparam int unsigned DATA_BITS  = 16;   // data field width
  localparam int unsigned SPAN_BITS  = 4;    // span field width
  localparam int unsigned CH_BITS    = 2;    // channel index width
  localparam int unsigned CNT_BITS   = 5;    // serial edge counter width
  localparam int unsigned FIFO_DEPTH = 8;    // words held between the domains
  localparam int unsigned SYNC_BITS  = 3;    // synchronised levels

  localparam logic [CNT_BITS-1:0] LAST_EDGE = 5'h17;  // index of the 24th rising edge
  localparam logic [CNT_BITS-1:0] RB_START  = 5'h08;  // edges seen when readback starts
  localparam logic [DATA_BITS-1:0] ZERO_DATA = 16'h0000;
  localparam logic [SPAN_BITS-1:0] ZERO_SPAN = 4'h0;

  // bit positions inside the synchroniser vector
  localparam int unsigned SY_TGL = 0;
  localparam int unsigned SY_UPD = 1;
  localparam int unsigned SY_CLR = 2;

  // command nibble
  typedef enum logic [CMD_BITS-1:0] {
    CMD_WR_SPAN      = 4'h2, CMD_WR_CODE      = 4'h3,
    CMD_UPD_CH       = 4'h4, CMD_UPD_ALL      = 4'h5,
    CMD_WR_SPAN_UPD  = 4'h6, CMD_WR_CODE_UPD  = 4'h7,
    CMD_WR_SPAN_UALL = 4'h8, CMD_WR_CODE_UALL = 4'h9,
    CMD_RD_B1_SPAN   = 4'ha, CMD_RD_B1_CODE   = 4'hb,
    CMD_RD_B2_SPAN   = 4'hc, CMD_RD_B2_CODE   = 4'hd,
    CMD_SLEEP        = 4'he, CMD_NOP          = 4'hf
  } cmd_t;

  // one serial word, most significant field first
  typedef struct packed {
    logic [CMD_BITS-1:0]  cmd;
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } word_t;

  localparam int unsigned WORD_BITS = $bits(word_t);

  // one buffer of one channel: code and span
  typedef struct packed {
    logic [DATA_BITS-1:0] code;
    logic [SPAN_BITS-1:0] span;
  } chan_t;

  // readback pointer: which buffer of which channel goes out next
  typedef struct packed {
    logic               active;
    logic               span;
    logic [CH_BITS-1:0] ch;
  } rb_sel_t;

endpackage

// *** testbench/host_model.sv ***
// Purpose: host controller model driving the serial link and the level pins
// Assumes: serial clock period 64 ns, idle low between frames
// Notes:   readback pin is resolved here from the data and its enable
`timescale 1ns/1ps
`default_nettype none

module host_model
  import dac_ctl_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic sro_i,
  input  wire logic sro_oe_i,
  output logic      sck_o,
  output logic      sel_n_o,
  output logic      sdi_o,
  output logic      upd_n_o,
  output logic      clr_n_o
);
  wire sro_wire;  // resolved readback pin level

  assign sro_wire = sro_oe_i ? sro_i : 1'bz;

  // idle levels: clock parked low, nothing selected
  initial begin
    sck_o   = 1'b0;
    sel_n_o = 1'b1;
    sdi_o   = 1'b0;
    upd_n_o = 1'b1;
    clr_n_o = 1'b1;
  end

  task automatic send_word(input word_t w, output logic [DATA_BITS-1:0] rb,
                           output logic oe_ok);
    oe_ok   = 1'b1;
    sel_n_o = 1'b0;
    for (int i = WORD_BITS - 1; i >= 0; i--) begin
      sdi_o = w[i];
      #32;
      // pin must be driven once the first falling edge has passed
      if (i < WORD_BITS - 1 && sro_oe_i !== 1'b1) begin
        oe_ok = 1'b0;
      end
      // sample before the rising edge, bit was launched on the falling one
      if (i < DATA_BITS) begin
        rb[i] = sro_wire;
      end
      sck_o = 1'b1;
      #32 sck_o = 1'b0;
    end
    #32 sel_n_o = 1'b1;
    // released data line must not look like the last bit
    sdi_o = ~sdi_o;
  endtask

  // select stays high while pins move
  task automatic set_pins(input logic upd_n, input logic clr_n);
    @(posedge mclk_i);
    #1;
    upd_n_o = upd_n;
    clr_n_o = clr_n;
  endtask
endmodule

`default_nettype wire

// *** testbench/quad_dac_serial_control_test.sv ***
// Purpose: self-checking bench for the quad DAC serial control front end
// Assumes: words execute within a few system clocks after select rises
// Notes:   read commands report on the following word
`timescale 1ns/1ps
`default_nettype none

module quad_dac_serial_control_test;
  import dac_ctl_pkg::*;
  localparam int CW = $bits(chan_t) * CHANNELS;  // width of the active bank

  logic                 mclk;     // system clock
  logic                 reset_n;  // reset, synchronous except for word_r and word_tgl_r
  logic                 sck;      // link clock from host
  logic                 sel_n;    // select/load
  logic                 serial_in;      // serial data
  logic                 upd_n;    // update pin
  logic                 clr_n;    // clear pin
  logic                 readback_out;      // readback data
  logic                 sro_oe;   // readback enable
  logic                 flag_n;   // reset flag
  chan_t [CHANNELS-1:0] active;   // active buffers
  logic  [CHANNELS-1:0] sleep;    // sleep status
  chan_t [CHANNELS-1:0] exp_act;  // expected active buffers
  logic [DATA_BITS-1:0] rb;       // readback of last word
  logic                 oe_ok;    // enable held through frame
  int                   errors;
  int                   n_tests;

  dac_serial_ctl dut (
    .MCLK_I          (mclk),
    .RESET_N_I       (reset_n),
    .SCK_I           (sck),
    .SELECT_LOAD_N_I (sel_n),
    .SERIAL_IN_I     (serial_in),
    .ASYNC_UPDATE_N_I(upd_n),
    .ASYNC_CLEAR_N_I (clr_n),
    .READBACK_OUT_O  (readback_out),
    .READBACK_OE_O   (sro_oe),
    .RESET_FLAG_N_O  (flag_n),
    .ACTIVE_O        (active),
    .SLEEP_O         (sleep)
  );

  host_model host (
    .mclk_i  (mclk),
    .sro_i   (readback_out),
    .sro_oe_i(sro_oe),
    .sck_o   (sck),
    .sel_n_o (sel_n),
    .sdi_o   (serial_in),
    .upd_n_o (upd_n),
    .clr_n_o (clr_n)
  );

  // 25 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // one comparison, wide enough for the whole active bank
  task automatic check(input logic [CW-1:0] got, input logic [CW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // margin beyond the 4..6 cycle execution latency
  task automatic settle();
    repeat (12) @(posedge mclk);
    #1;
  endtask

  task automatic word(input cmd_t c, input logic [3:0] a, input logic [15:0] d);
    host.send_word({c, a, d}, rb, oe_ok);
    settle();
    check(CW'(oe_ok), CW'(1'b1));
    check(CW'(sro_oe), CW'(1'b0));
  endtask

  // flag low, outputs zero, pin released out of reset
  task automatic t_reset();
    check(active, '0);
    check(CW'(flag_n), CW'(1'b0));
    check(CW'(sro_oe), CW'(1'b0));
  endtask

  // holding write leaves outputs alone until an update command
  task automatic t_write_update();
    word(CMD_WR_CODE, 4'h1, 16'h1234);
    check(active, '0);
    word(CMD_UPD_ALL, 4'h0, 16'h0000);
    check(CW'(rb), CW'(16'h1234));
    exp_act[1] = {16'h1234, 4'h0};
    check(active, exp_act);
    check(CW'(flag_n), CW'(1'b1));
  endtask

  // rolling readback of active code and holding span
  task automatic t_readback();
    word(CMD_RD_B2_CODE, 4'h1, 16'h0000);
    word(CMD_NOP, 4'h0, 16'h0000);
    check(CW'(rb), CW'(16'h1234));
    word(CMD_WR_SPAN, 4'h2, 16'h0003);
    word(CMD_WR_CODE, 4'h2, 16'habcd);
    check(CW'(rb), CW'(16'h0003));
    check(active, exp_act);
  endtask

  // update pin copies every channel and wakes the sleeper
  task automatic t_update_pin();
    word(CMD_SLEEP, 4'h3, 16'h0000);
    check(CW'(sleep), CW'(4'h8));
    host.set_pins(1'b0, 1'b1);
    settle();
    host.set_pins(1'b1, 1'b1);
    settle();
    exp_act[2] = {16'habcd, 4'h3};
    check(active, exp_act);
    check(CW'(sleep), CW'(4'h0));
  endtask

  // clear zeroes active side only, holding survives
  task automatic t_clear();
    host.set_pins(1'b1, 1'b0);
    settle();
    check(active, '0);
    check(CW'(flag_n), CW'(1'b0));
    host.set_pins(1'b1, 1'b1);
    settle();
    host.set_pins(1'b0, 1'b1);
    settle();
    host.set_pins(1'b1, 1'b1);
    settle();
    check(active, exp_act);
  endtask

  // clear and update together: clear must win
  task automatic t_clear_wins();
    host.set_pins(1'b0, 1'b0);
    settle();
    check(active, '0);
    check(CW'(flag_n), CW'(1'b0));
    host.set_pins(1'b1, 1'b0);
    settle();
    host.set_pins(1'b1, 1'b1);
    settle();
    check(active, '0);
  endtask

  // write-and-update commands release the flag and move the written channel
  task automatic t_write_and_update();
    word(CMD_WR_CODE_UPD, 4'h0, 16'h5a5a);
    check(CW'(active[0]), CW'({16'h5a5a, 4'h0}));
    check(CW'(flag_n), CW'(1'b1));
    word(CMD_RD_B1_CODE, 4'h0, 16'h0000);
    word(CMD_WR_SPAN_UALL, 4'h0, 16'h0002);
    check(CW'(rb), CW'(16'h5a5a));
    exp_act[0] = {16'h5a5a, 4'h2};
    check(active, exp_act);
  endtask

  // main sequence: six-cycle reset, then the scenarios
  initial begin
    errors  = 0;
    n_tests = 0;
    exp_act = '0;
    reset_n = 1'b0;
    repeat (6) @(posedge mclk);
    #1 reset_n = 1'b1;
    @(posedge mclk);
    #7;
    t_reset();
    t_write_update();
    t_readback();
    t_update_pin();
    t_clear();
    t_clear_wins();
    t_write_and_update();
    test_done();
  end

  // hang guard, several times the expected run length
  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule

`default_nettype wire
